//--- common/clock_out_map.vh
// Register map, field positions, reset values and source codes for the
// clock-out and pad function select block.
// Assumes a byte-addressed AHB-Lite slave with one 32-bit word per register.
`ifndef CLOCK_OUT_MAP_VH
`define CLOCK_OUT_MAP_VH

// ----------------------------------------------------------------------
// Register indices and byte addresses
// ----------------------------------------------------------------------
`define IDX_CLOCK_OUT_SELECT 8'h0a
`define IDX_PERIPH_ALT_SELECT 8'h0b
`define ADR_CLOCK_OUT_SELECT 8'h28
`define ADR_PERIPH_ALT_SELECT 8'h2c
`define ADR_PORT_B_PERIPH_EN 8'h40
`define ADR_PORT_C_PERIPH_EN 8'h44
`define ADR_PORT_C_DIRECTION 8'h48
`define ADR_PORT_C_DATA 8'h4c
`define ADR_PAD_STATUS 8'h50

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define CLOCK_OUT_PIN_SRC_LSB 0
`define CLOCK_OUT_PIN_SRC_MSB 4
`define CLOCK_OUT_PIN_OFF_BIT 5
`define CLOCK_OUT_PIN_ALT_LSB 6
`define CLOCK_OUT_PIN_ALT_MSB 9
`define GPS_PORT_C_LSB 0
`define GPS_PORT_C_MSB 3
`define GPS_PORT_D_LSB 4
`define GPS_PORT_D_MSB 5

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RST_CLOCK_OUT_PIN_SRC 5'h00
`define RST_CLOCK_OUT_PIN_OFF 1'b1
`define RST_CLOCK_OUT_PIN_ALT 4'h0
`define RST_GPS 6'h00
`define RST_PORT_B_PERIPH_EN 4'h0
`define RST_PORT_C_PERIPH_EN 4'hf
`define RST_PORT_C_DIRECTION 4'h0
`define RST_PORT_C_DATA 4'h0

// ----------------------------------------------------------------------
// Clock-out source codes
// ----------------------------------------------------------------------
`define SRC_SYSTEM 5'h00
`define SRC_OSCILLATOR 5'h07
`define SRC_PLL 5'h08
`define SRC_CONVERTER_A 5'h10
`define SRC_CONVERTER_B 5'h11

`endif

//--- hdl/clock_out_pad_mux.v
// Clock-out source select and pad function select for port B and port C.
// Assumes an AHB-Lite master on hclk; clock sources are glitch-free sources.
//
// Behaviour
// RULE1 - Five-bit source field steers system, oscillator, PLL, converter A or B clock out.
// RULE2 - Factory test codes are reserved; here they output a constant low.
// RULE3 - Disable bit 5 tri-states clock-out pin; resets to one.
// RULE4 - Bit 9: port B pin 7 carries address 23 or raw oscillator clock.
// RULE5 - Bit 8: port B pin 6 carries address 22 or double-rate system clock.
// RULE6 - Bit 7: port B pin 5 carries address 21 or system clock.
// RULE7 - Bit 6: port B pin 4 carries address 20 or prescaler reference clock.
// RULE8 - Port B peripheral enable wins; alternate choice only in peripheral mode.
// RULE9 - After reset port B peripheral pins carry address lines 23 to 20.
// RULE10 - Clock-out select bits 15 to 10 read zero and ignore writes.
// RULE11 - Peripheral select applies only to port C pins 0-3 and D pins 0-1.
// RULE12 - Port C pins reset to peripheral mode; GPIO follows direction setting.
// RULE13 - Port C select 0 routes decoder/timer, 1 routes second SPI.
// RULE14 - Timer route drives pad when timer output enable set, else input.
// RULE15 - SPI route takes pad direction from the SPI block itself.
// RULE16 - Every port C pin has its own enable, direction and select controls.
// RULE17 - After reset port C peripheral pins carry decoder/timer functions.
// RULE18 - Select bits 3..0 map pins 3..0 to slave select, data-in, data-out, clock.
// RULE19 - Source codes 10010 to 11111 output constant low while enabled.
//
// Decided for this implementation: register access over AHB-Lite.
`timescale 1ns/100ps
`include "clock_out_map.vh"

module clock_out_pad_mux #(
  parameter PORT_C_PINS = 4
) (
  hclk,
  hresetn,
  hsel,
  haddr,
  htrans,
  hwrite,
  hsize,
  hwdata,
  hready,
  hreadyout,
  hrdata,
  hresp,
  core_system_clock,
  double_rate_system_clock,
  raw_oscillator_clock,
  prescaled_reference_clock,
  pll_output_clock,
  converter_a_clock,
  converter_b_clock,
  clock_out_pin,
  clock_out_oe,
  address_hi,
  gpio_b_out,
  gpio_b_oe,
  port_b_pad_out,
  port_b_pad_oe,
  port_d_alt_select,
  timer_out,
  timer_output_enable,
  spi_out,
  spi_oe,
  port_c_pad_in,
  port_c_pad_out,
  port_c_pad_oe,
  timer_in,
  spi_in
);
  input wire hclk;
  input wire hresetn;
  input wire hsel;
  input wire [31:0] haddr;
  input wire [1:0] htrans;
  input wire hwrite;
  input wire [2:0] hsize;
  input wire [31:0] hwdata;
  input wire hready;
  output reg hreadyout;
  output reg [31:0] hrdata;
  output reg hresp;
  input wire core_system_clock;
  input wire double_rate_system_clock;
  input wire raw_oscillator_clock;
  input wire prescaled_reference_clock;
  input wire pll_output_clock;
  input wire converter_a_clock;
  input wire converter_b_clock;
  output reg clock_out_pin;
  output reg clock_out_oe;
  input wire [3:0] address_hi;
  input wire [3:0] gpio_b_out;
  input wire [3:0] gpio_b_oe;
  output reg [3:0] port_b_pad_out;
  output reg [3:0] port_b_pad_oe;
  output reg [1:0] port_d_alt_select;
  input wire [PORT_C_PINS-1:0] timer_out;
  input wire [PORT_C_PINS-1:0] timer_output_enable;
  input wire [PORT_C_PINS-1:0] spi_out;
  input wire [PORT_C_PINS-1:0] spi_oe;
  input wire [PORT_C_PINS-1:0] port_c_pad_in;
  output wire [PORT_C_PINS-1:0] port_c_pad_out;
  output wire [PORT_C_PINS-1:0] port_c_pad_oe;
  output wire [PORT_C_PINS-1:0] timer_in;
  output wire [PORT_C_PINS-1:0] spi_in;

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  reg [4:0] clock_out_source_r;
  reg [4:0] clock_out_source_nxt;
  reg clock_out_off_r;
  reg clock_out_off_nxt;
  reg [3:0] pin_alt_select_r;
  reg [3:0] pin_alt_select_nxt;
  reg [5:0] periph_alt_select_r;
  reg [5:0] periph_alt_select_nxt;
  reg [3:0] port_b_periph_enable_r;
  reg [3:0] port_b_periph_enable_nxt;
  reg [PORT_C_PINS-1:0] port_c_periph_enable_r;
  reg [PORT_C_PINS-1:0] port_c_periph_enable_nxt;
  reg [PORT_C_PINS-1:0] port_c_direction_r;
  reg [PORT_C_PINS-1:0] port_c_direction_nxt;
  reg [PORT_C_PINS-1:0] port_c_data_r;
  reg [PORT_C_PINS-1:0] port_c_data_nxt;
  reg wr_pend_r;
  reg [7:0] wr_addr_r;
  reg [31:0] rdata_nxt;
  wire [PORT_C_PINS-1:0] gpio_c_in;
  wire addr_phase;

  // ----------------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------------
  // Zero wait states; reads see the write in flight so back-to-back
  // write then read of one register returns the new value.
  assign addr_phase = hsel & hready & htrans[1];

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h00000000;
    end else begin
      wr_pend_r <= addr_phase & hwrite;
      wr_addr_r <= haddr[7:0];
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (addr_phase & ~hwrite) begin
        hrdata <= rdata_nxt;
      end
    end
  end

  always @* begin
    clock_out_source_nxt = clock_out_source_r;
    clock_out_off_nxt = clock_out_off_r;
    pin_alt_select_nxt = pin_alt_select_r;
    periph_alt_select_nxt = periph_alt_select_r;
    port_b_periph_enable_nxt = port_b_periph_enable_r;
    port_c_periph_enable_nxt = port_c_periph_enable_r;
    port_c_direction_nxt = port_c_direction_r;
    port_c_data_nxt = port_c_data_r;
    if (wr_pend_r) begin
      case (wr_addr_r)
        `ADR_CLOCK_OUT_SELECT: begin
          // Bits 15..10 are not stored
          clock_out_source_nxt = hwdata[`CLOCK_OUT_PIN_SRC_MSB:`CLOCK_OUT_PIN_SRC_LSB]; // RULE10
          clock_out_off_nxt = hwdata[`CLOCK_OUT_PIN_OFF_BIT];
          pin_alt_select_nxt = hwdata[`CLOCK_OUT_PIN_ALT_MSB:`CLOCK_OUT_PIN_ALT_LSB];
        end
        `ADR_PERIPH_ALT_SELECT: begin
          periph_alt_select_nxt = hwdata[`GPS_PORT_D_MSB:`GPS_PORT_C_LSB]; // RULE11
        end
        `ADR_PORT_B_PERIPH_EN: begin
          port_b_periph_enable_nxt = hwdata[3:0];
        end
        `ADR_PORT_C_PERIPH_EN: begin
          port_c_periph_enable_nxt = hwdata[PORT_C_PINS-1:0]; // RULE16
        end
        `ADR_PORT_C_DIRECTION: begin
          port_c_direction_nxt = hwdata[PORT_C_PINS-1:0]; // RULE16
        end
        `ADR_PORT_C_DATA: begin
          port_c_data_nxt = hwdata[PORT_C_PINS-1:0];
        end
        default: begin
          port_c_data_nxt = port_c_data_r;
        end
      endcase
    end
  end

  always @* begin
    rdata_nxt = 32'h00000000;
    case (haddr[7:0])
      `ADR_CLOCK_OUT_SELECT: begin
        rdata_nxt[`CLOCK_OUT_PIN_SRC_MSB:`CLOCK_OUT_PIN_SRC_LSB] = clock_out_source_nxt;
        rdata_nxt[`CLOCK_OUT_PIN_OFF_BIT] = clock_out_off_nxt;
        rdata_nxt[`CLOCK_OUT_PIN_ALT_MSB:`CLOCK_OUT_PIN_ALT_LSB] = pin_alt_select_nxt; // RULE10
      end
      `ADR_PERIPH_ALT_SELECT: begin
        rdata_nxt[`GPS_PORT_D_MSB:`GPS_PORT_C_LSB] = periph_alt_select_nxt;
      end
      `ADR_PORT_B_PERIPH_EN: begin
        rdata_nxt[3:0] = port_b_periph_enable_nxt;
      end
      `ADR_PORT_C_PERIPH_EN: begin
        rdata_nxt[PORT_C_PINS-1:0] = port_c_periph_enable_nxt;
      end
      `ADR_PORT_C_DIRECTION: begin
        rdata_nxt[PORT_C_PINS-1:0] = port_c_direction_nxt;
      end
      `ADR_PORT_C_DATA: begin
        rdata_nxt[PORT_C_PINS-1:0] = port_c_data_nxt;
      end
      `ADR_PAD_STATUS: begin
        rdata_nxt[PORT_C_PINS-1:0] = gpio_c_in;
      end
      default: begin
        rdata_nxt = 32'h00000000;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // Configuration state
  // ----------------------------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clock_out_source_r <= `RST_CLOCK_OUT_PIN_SRC;
      clock_out_off_r <= `RST_CLOCK_OUT_PIN_OFF; // RULE3
      pin_alt_select_r <= `RST_CLOCK_OUT_PIN_ALT; // RULE9
      periph_alt_select_r <= `RST_GPS; // RULE17
      port_b_periph_enable_r <= `RST_PORT_B_PERIPH_EN;
      port_c_periph_enable_r <= `RST_PORT_C_PERIPH_EN; // RULE12
      port_c_direction_r <= `RST_PORT_C_DIRECTION;
      port_c_data_r <= `RST_PORT_C_DATA;
      clock_out_oe <= 1'b0;
      port_d_alt_select <= 2'h0;
    end else begin
      clock_out_source_r <= clock_out_source_nxt;
      clock_out_off_r <= clock_out_off_nxt;
      pin_alt_select_r <= pin_alt_select_nxt;
      periph_alt_select_r <= periph_alt_select_nxt;
      port_b_periph_enable_r <= port_b_periph_enable_nxt;
      port_c_periph_enable_r <= port_c_periph_enable_nxt;
      port_c_direction_r <= port_c_direction_nxt;
      port_c_data_r <= port_c_data_nxt;
      clock_out_oe <= ~clock_out_off_nxt; // RULE3
      port_d_alt_select <= periph_alt_select_nxt[`GPS_PORT_D_MSB:`GPS_PORT_D_LSB]; // RULE11
    end
  end

  // ----------------------------------------------------------------------
  // Clock-out mux
  // ----------------------------------------------------------------------
  // Clock paths cannot pass through a flop at hclk rate; only the select
  // and enable are registered. Source changes are not glitch-protected.
  always @* begin
    case (clock_out_source_r)
      `SRC_SYSTEM: clock_out_pin = core_system_clock; // RULE1
      `SRC_OSCILLATOR: clock_out_pin = raw_oscillator_clock; // RULE1
      `SRC_PLL: clock_out_pin = pll_output_clock; // RULE1
      `SRC_CONVERTER_A: clock_out_pin = converter_a_clock; // RULE1
      `SRC_CONVERTER_B: clock_out_pin = converter_b_clock; // RULE1
      // Test clocks are not brought into this block
      default: clock_out_pin = 1'b0; // RULE2 RULE19
    endcase
    if (clock_out_off_r) begin
      clock_out_pin = 1'b0; // RULE3
    end
  end

  // ----------------------------------------------------------------------
  // Port B pins 7..4
  // ----------------------------------------------------------------------
  always @* begin
    port_b_pad_out = gpio_b_out;
    port_b_pad_oe = gpio_b_oe;
    if (port_b_periph_enable_r[3]) begin // RULE8
      port_b_pad_out[3] = pin_alt_select_r[3] ? raw_oscillator_clock : address_hi[3]; // RULE4
      port_b_pad_oe[3] = 1'b1;
    end
    if (port_b_periph_enable_r[2]) begin // RULE8
      port_b_pad_out[2] = pin_alt_select_r[2] ? double_rate_system_clock : address_hi[2]; // RULE5
      port_b_pad_oe[2] = 1'b1;
    end
    if (port_b_periph_enable_r[1]) begin // RULE8
      port_b_pad_out[1] = pin_alt_select_r[1] ? core_system_clock : address_hi[1]; // RULE6
      port_b_pad_oe[1] = 1'b1;
    end
    if (port_b_periph_enable_r[0]) begin // RULE8
      port_b_pad_out[0] = pin_alt_select_r[0] ? prescaled_reference_clock : address_hi[0]; // RULE7
      port_b_pad_oe[0] = 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Port C pins 3..0
  // ----------------------------------------------------------------------
  // SPI order per pin index 3..0: slave select, data-in, data-out, clock
  genvar gi;
  generate
    for (gi = 0; gi < PORT_C_PINS; gi = gi + 1) begin : g_port_c
      port_c_pad_cell u_cell (
        .periph_enable(port_c_periph_enable_r[gi]),
        .direction(port_c_direction_r[gi]),
        .alt_select(periph_alt_select_r[gi]), // RULE18
        .gpio_out(port_c_data_r[gi]),
        .timer_out(timer_out[gi]),
        .timer_output_enable(timer_output_enable[gi]),
        .spi_out(spi_out[gi]),
        .spi_oe(spi_oe[gi]),
        .pad_in(port_c_pad_in[gi]),
        .pad_out(port_c_pad_out[gi]),
        .pad_oe(port_c_pad_oe[gi]),
        .timer_in(timer_in[gi]),
        .spi_in(spi_in[gi]),
        .gpio_in(gpio_c_in[gi])
      );
    end
  endgenerate

endmodule

//--- hdl/port_c_pad_cell.v
// One port C pad: GPIO, decoder/timer or second SPI function.
// Assumes the timer and SPI blocks supply their own output enables.
`timescale 1ns/100ps

module port_c_pad_cell (
  periph_enable,
  direction,
  alt_select,
  gpio_out,
  timer_out,
  timer_output_enable,
  spi_out,
  spi_oe,
  pad_in,
  pad_out,
  pad_oe,
  timer_in,
  spi_in,
  gpio_in
);
  input wire periph_enable;
  input wire direction;
  input wire alt_select;
  input wire gpio_out;
  input wire timer_out;
  input wire timer_output_enable;
  input wire spi_out;
  input wire spi_oe;
  input wire pad_in;
  output reg pad_out;
  output reg pad_oe;
  output wire timer_in;
  output wire spi_in;
  output wire gpio_in;

  // Inputs reach every function; only the selected one drives the pad
  assign timer_in = pad_in;
  assign spi_in = pad_in;
  assign gpio_in = pad_in;

  always @* begin
    pad_out = 1'b0;
    pad_oe = 1'b0;
    if (!periph_enable) begin
      pad_out = gpio_out; // RULE12
      pad_oe = direction; // RULE12
    end else if (!alt_select) begin
      pad_out = timer_out; // RULE13
      pad_oe = timer_output_enable; // RULE14
    end else begin
      pad_out = spi_out; // RULE13
      pad_oe = spi_oe; // RULE15
    end
  end

endmodule

//--- tb/clock_out_pad_mux_assertions.sv
// Checker for the clock-out and pad select block, bound to its ports.
// Assumes single AHB-Lite word writes; keeps a shadow of the written registers.
`timescale 1ns/100ps
module clock_out_pad_checker #(parameter PORT_C_PINS = 4) (
  input wire logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp,
  input wire logic [31:0] haddr, hwdata,
  input wire logic [1:0] htrans,
  input wire logic core_system_clock, double_rate_system_clock, raw_oscillator_clock,
  input wire logic prescaled_reference_clock, pll_output_clock,
  input wire logic converter_a_clock, converter_b_clock, clock_out_pin, clock_out_oe,
  input wire logic [3:0] address_hi, gpio_b_out, gpio_b_oe, port_b_pad_out, port_b_pad_oe,
  input wire logic [1:0] port_d_alt_select,
  input wire logic [PORT_C_PINS-1:0] timer_out, timer_output_enable, spi_out, spi_oe,
  input wire logic [PORT_C_PINS-1:0] port_c_pad_in, port_c_pad_out, port_c_pad_oe,
  input wire logic [PORT_C_PINS-1:0] timer_in, spi_in
);
  // ----------------------------------------------------------------------
  // Shadow registers
  // ----------------------------------------------------------------------
  logic [7:0] wa_r;
  logic [9:0] cs_r;
  logic [3:0] pb_r, pc_r, dir_r, dat_r, gps_r;
  logic exp_pin;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wa_r <= 8'h00; cs_r <= 10'h020; pb_r <= 4'h0; pc_r <= 4'hf;
      dir_r <= 4'h0; dat_r <= 4'h0; gps_r <= 4'h0;
    end else begin
      wa_r <= (hsel && hready && htrans[1] && hwrite) ? haddr[7:0] : 8'h00;
      case (wa_r)
        8'h28: cs_r <= hwdata[9:0];
        8'h2c: gps_r <= hwdata[3:0];
        8'h40: pb_r <= hwdata[3:0];
        8'h44: pc_r <= hwdata[3:0];
        8'h48: dir_r <= hwdata[3:0];
        8'h4c: dat_r <= hwdata[3:0];
        default: ;
      endcase
    end
  end
  wire [6:0] s7 = {prescaled_reference_clock, double_rate_system_clock, converter_b_clock,
    converter_a_clock, pll_output_clock, raw_oscillator_clock, core_system_clock};
  always @* begin
    case (cs_r[4:0])
      5'h00: exp_pin = s7[0];
      5'h07: exp_pin = s7[1];
      5'h08: exp_pin = s7[2];
      5'h10: exp_pin = s7[3];
      5'h11: exp_pin = s7[4];
      default: exp_pin = 1'b0;
    endcase
  end
  wire [3:0] altv = {cs_r[9] ? s7[1] : address_hi[3], cs_r[8] ? s7[5] : address_hi[2],
    cs_r[7] ? s7[0] : address_hi[1], cs_r[6] ? s7[6] : address_hi[0]};
  wire [3:0] en_t = pc_r & ~gps_r;
  wire [3:0] en_s = pc_r & gps_r;
  wire [3:0] c_oe = (en_t & timer_output_enable) | (en_s & spi_oe) | (~pc_r & dir_r);
  wire [3:0] c_out = (en_t & timer_out) | (en_s & spi_out) | (~pc_r & dat_r);
  // ----------------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_ctl_write;
    hsel && hready && htrans[1] && hwrite && haddr[7:0] == 8'h28;
  endsequence
  sequence s_sel_write;
    hsel && hready && htrans[1] && hwrite && haddr[7:0] == 8'h2c;
  endsequence
  a_oe_after_write: assert property (s_ctl_write ##1 1'b1 |=>
    clock_out_oe == !$past(hwdata[5])) else $error("clock-out enable wrong after write");
  a_oe_reset_off: assert property ($rose(hresetn) |-> !clock_out_oe)
    else $error("clock-out driven right after reset");
  a_pin_low_off: assert property (!clock_out_oe |-> !clock_out_pin)
    else $error("clock-out pin not low while off");
  a_source_mux: assert property (clock_out_oe |-> clock_out_pin == exp_pin)
    else $error("clock-out source wrong");
  a_portb_gpio_mode: assert property (((port_b_pad_out ^ gpio_b_out) & ~pb_r) == 4'h0 &&
    ((port_b_pad_oe ^ gpio_b_oe) & ~pb_r) == 4'h0) else $error("port B gpio pin wrong");
  a_portb_alt_out: assert property (((port_b_pad_out ^ altv) & pb_r) == 4'h0 &&
    (port_b_pad_oe | ~pb_r) == 4'hf) else $error("port B peripheral pin wrong");
  a_portc_dir: assert property (port_c_pad_oe == c_oe)
    else $error("port C pad enable wrong");
  a_portc_route: assert property (((port_c_pad_out ^ c_out) & c_oe) == 4'h0)
    else $error("port C pad drive wrong");
  a_pad_in_pass: assert property (timer_in == port_c_pad_in && spi_in == port_c_pad_in)
    else $error("pad input not passed on");
  a_portd_select: assert property (s_sel_write ##1 1'b1 |=>
    port_d_alt_select == $past(hwdata[5:4])) else $error("port D select wrong");
  // Zero-wait slave: a stall or error response would hang or break the master
  a_bus_always_okay: assert property (hreadyout && !hresp)
    else $error("bus response not ready or not okay");
endmodule
bind clock_out_pad_mux clock_out_pad_checker #(.PORT_C_PINS(PORT_C_PINS)) chk_i (.hclk,
  .hresetn, .hsel, .hwrite, .hready, .hreadyout, .hresp, .haddr, .hwdata, .htrans,
  .core_system_clock,
  .double_rate_system_clock, .raw_oscillator_clock, .prescaled_reference_clock,
  .pll_output_clock, .converter_a_clock, .converter_b_clock, .clock_out_pin, .clock_out_oe,
  .address_hi, .gpio_b_out, .gpio_b_oe, .port_b_pad_out, .port_b_pad_oe, .port_d_alt_select,
  .timer_out, .timer_output_enable, .spi_out, .spi_oe, .port_c_pad_in, .port_c_pad_out,
  .port_c_pad_oe, .timer_in, .spi_in);

//--- tb/clock_out_pad_mux_tb_top.sv
// Self-checking bench for the clock-out and pad select block.
// Assumes a single-slave AHB-Lite bus; all side inputs are random each cycle.
`timescale 1ns/100ps
module clock_out_pad_mux_tb_top;
  logic hclk = 0, hresetn = 0, hwrite = 0;
  logic [31:0] haddr = 0, hwdata = 0, r = 32'h00015030, q, v;
  logic [1:0] htrans = 0;
  logic [6:0] src = 0;
  logic [3:0] ah = 0, gbo = 0, gbe = 0, t_o = 0, t_e = 0, s_o = 0, s_e = 0, en, sel, coe;
  wire hreadyout, hresp, clk_pin, clk_oe;
  wire [31:0] hrdata;
  wire [3:0] pbo, pbe, pci, pco, pce, tin, sin;
  wire [1:0] pds;
  int n_errors = 0, cmp_count = 0, cyc = 0;
  always #5 hclk = ~hclk;
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13; x ^= x >> 17; x ^= x << 5;
    return x;
  endfunction
  // ----------------------------------------------------------------------
  // Random side inputs and hang guard
  // ----------------------------------------------------------------------
  always @(posedge hclk) begin
    r <= xs(r);
    {src, ah, gbo, gbe, t_o, t_e, s_o, s_e} <= {r, r[31:29]};
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      complete_run;
    end
  end
  clock_out_pad_mux clock_out_pad_mux_i (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .core_system_clock(src[0]), .raw_oscillator_clock(src[1]), .pll_output_clock(src[2]),
    .converter_a_clock(src[3]), .converter_b_clock(src[4]), .double_rate_system_clock(src[5]),
    .prescaled_reference_clock(src[6]), .clock_out_pin(clk_pin), .clock_out_oe(clk_oe),
    .address_hi(ah), .gpio_b_out(gbo), .gpio_b_oe(gbe), .port_b_pad_out(pbo),
    .port_b_pad_oe(pbe), .port_d_alt_select(pds), .timer_out(t_o), .timer_output_enable(t_e),
    .spi_out(s_o), .spi_oe(s_e), .port_c_pad_in(pci), .port_c_pad_out(pco),
    .port_c_pad_oe(pce), .timer_in(tin), .spi_in(sin));
  pad_board_model pad_board_model_i (.clk(hclk), .pad_out(pco), .pad_oe(pce), .pad_in(pci));
  // ----------------------------------------------------------------------
  // Bus tasks and expectations
  // ----------------------------------------------------------------------
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    htrans <= 2'h2; haddr <= {24'h0, a}; hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0; hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  function automatic logic exp_clk(input logic [4:0] c);
    case (c)
      5'h00: return src[0];
      5'h07: return src[1];
      5'h08: return src[2];
      5'h10: return src[3];
      5'h11: return src[4];
      default: return 1'b0;
    endcase
  endfunction
  function automatic logic [3:0] exp_pb(input logic [3:0] e, input logic [3:0] alt);
    logic [3:0] a;
    a = {alt[3] ? src[1] : ah[3], alt[2] ? src[5] : ah[2], alt[1] ? src[0] : ah[1],
      alt[0] ? src[6] : ah[0]};
    return (e & a) | (~e & gbo);
  endfunction
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(negedge hclk) chk(clk_oe, 0);
    @(posedge hclk);
    rdc(8'h28, 32'h20);
    rdc(8'h2c, 32'h0);
    rdc(8'h44, 32'hf);
    rdc(8'h70, 32'h0);
    xfer(1'b1, 8'h28, 32'hfffffc07);
    rdc(8'h28, 32'h7);
    $display("end of reset and reserved bits");
    for (int c = 0; c < 32; c++) begin
      xfer(1'b1, 8'h28, c);
      repeat (3) begin
        @(negedge hclk);
        chk(clk_pin, exp_clk(c[4:0]));
        chk(clk_oe, 1);
      end
      @(posedge hclk);
    end
    xfer(1'b1, 8'h28, 32'h20);
    @(negedge hclk) chk({clk_oe, clk_pin}, 0);
    @(posedge hclk);
    $display("end of clock-out sources");
    for (int i = 0; i < 12; i++) begin
      v = (i == 0) ? 32'h3c00 : r;
      xfer(1'b1, 8'h28, {22'h0, v[9:6], 6'h20});
      xfer(1'b1, 8'h40, v[13:10]);
      rdc(8'h28, {22'h0, v[9:6], 6'h20});
      @(negedge hclk) chk(pbo, exp_pb(v[13:10], v[9:6]));
      chk(pbe, v[13:10] | gbe);
      @(posedge hclk);
    end
    $display("end of port B");
    for (int i = 0; i < 12; i++) begin
      v = (i == 0) ? 32'hf : r;
      xfer(1'b1, 8'h44, v[3:0]);
      xfer(1'b1, 8'h2c, v[9:4]);
      xfer(1'b1, 8'h48, v[13:10]);
      xfer(1'b1, 8'h4c, v[17:14]);
      rdc(8'h2c, {26'h0, v[9:4]});
      en = v[3:0];
      sel = v[7:4];
      @(negedge hclk) chk(pds, v[9:8]);
      coe = (en & ~sel & t_e) | (en & sel & s_e) | (~en & v[13:10]);
      chk(pce, coe);
      chk(pco & coe, ((en & ~sel & t_o) | (en & sel & s_o) | (~en & v[17:14])) & coe);
      chk({tin, sin}, {pci, pci});
      @(posedge hclk);
    end
    xfer(1'b1, 8'h60, 32'hffffffff);
    rdc(8'h2c, {26'h0, v[9:4]});
    $display("end of port C and unmapped write");
    xfer(1'b1, 8'h44, 32'h0);
    xfer(1'b1, 8'h48, 32'hf);
    xfer(1'b1, 8'h4c, 32'ha);
    rdc(8'h50, 32'ha);
    // Second reset in mid-run must bring back the peripheral defaults
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    xfer(1'b1, 8'h40, 32'hf);
    @(negedge hclk) chk(pbo, ah);
    chk(pce, t_e);
    chk(pco & t_e, t_o & t_e);
    @(posedge hclk);
    $display("end of pad status and mid-run reset");
    complete_run;
  end
endmodule

//--- tb/pad_board_model.sv
// Board side of the port C pads: resolves each pad wire from the design drive.
// Assumes one clock; a pad nobody drives has no pull resistor on the board.
`timescale 1ns/100ps
module pad_board_model (
  input wire logic clk,
  input wire logic [3:0] pad_out,
  input wire logic [3:0] pad_oe,
  output logic [3:0] pad_in
);
  logic [3:0] float_r = 4'h5;
  // Floating pads flip every cycle so a wrong enable cannot read back by luck
  always @(posedge clk) float_r <= ~float_r;
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & float_r);
endmodule
